// ---- common/imsu_pkg.sv ----
package imsu_pkg;

  // ****************************************
  // function codes of the math instructions
  // ****************************************
  localparam logic [7:0] FC_ADD = 8'h50;
  localparam logic [7:0] FC_SUB = 8'h51;
  localparam logic [7:0] FC_PROD = 8'h52;
  localparam logic [7:0] FC_DIV = 8'h53;
  localparam logic [7:0] FC_WDIV = 8'h54;
  localparam logic [7:0] FC_ZERO = 8'h55;
  localparam logic [7:0] FC_ROOT = 8'h56;
  localparam logic [7:0] FC_SCL = 8'h57;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_TRAP = 8'h08;
  localparam logic [7:0] REG_MATH_LO = 8'h0c;
  localparam logic [7:0] REG_MATH_HI = 8'h10;
  localparam logic [7:0] REG_FAULT = 8'h14;

  // ****************************************
  // field positions and values
  // ****************************************
  localparam int FLG_CARRY = 0;
  localparam int FLG_OVF = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_SIGN = 3;
  localparam int CFG_OVF_SEL = 14;
  localparam int TRAP_MINOR = 0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] FAULT_MATH = 16'h0020;
  localparam logic [15:0] POS_LIMIT = 16'h7fff;
  localparam logic [15:0] NEG_LIMIT = 16'h8000;
  // width of a status word
  localparam int WORD_W = 16;

  typedef enum logic [3:0] {OP_NONE, OP_ADD, OP_SUB, OP_PROD, OP_DIV, OP_WDIV, OP_ZERO, OP_ROOT, OP_SCL} imsu_op_t;

  function automatic imsu_op_t decodeOp(input logic [7:0] fc);
    if (fc == FC_ADD) return OP_ADD;
    else if (fc == FC_SUB) return OP_SUB;
    else if (fc == FC_PROD) return OP_PROD;
    else if (fc == FC_DIV) return OP_DIV;
    else if (fc == FC_WDIV) return OP_WDIV;
    else if (fc == FC_ZERO) return OP_ZERO;
    else if (fc == FC_ROOT) return OP_ROOT;
    else if (fc == FC_SCL) return OP_SCL;
    else return OP_NONE;
  endfunction : decodeOp

  // byte-lane write into a 16-bit register held in the low lanes
  function automatic logic [15:0] wrMerge(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : wrMerge

  // true when a sign-extended value fits a signed 16-bit word
  function automatic logic fits16(input logic [32:0] v);
    return (&v[32:15]) | ~(|v[32:15]);
  endfunction : fits16

  function automatic logic [15:0] sat16(input logic [32:0] v);
    return v[32] ? NEG_LIMIT : POS_LIMIT;
  endfunction : sat16

endpackage : imsu_pkg

// ---- common/imsu_alu_if.sv ----
`timescale 1ns/1ns
interface imsu_alu_if;
  import imsu_pkg::*;
  imsu_op_t op;
  logic [15:0] opA;
  logic [15:0] opB;
  logic [15:0] opC;
  logic [31:0] mathWide;
  logic ovfSel;
  logic [15:0] result;
  logic carry;
  logic ovf;
  logic divZero;
  logic wideLoad;
  logic [31:0] wideVal;
  modport ctrl (output op, opA, opB, opC, mathWide, ovfSel, input result, carry, ovf, divZero, wideLoad, wideVal);
  modport alu (input op, opA, opB, opC, mathWide, ovfSel, output result, carry, ovf, divZero, wideLoad, wideVal);
endinterface : imsu_alu_if

// ---- rtl/imsu_arith.sv ----
`timescale 1ns/1ns
module imsu_arith (
  imsu_alu_if.alu bus // operands in, result and status out
);
  import imsu_pkg::*;

  function automatic logic [7:0] isqrt(input logic [15:0] v);
    logic [7:0] r;
    logic [7:0] t;
    r = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      t = r | 8'(8'h01 << i);
      if ({8'h00, t} * {8'h00, t} <= v) r = t;
    end
    return r;
  endfunction : isqrt

  wire logic [32:0] a33 = {{17{bus.opA[15]}}, bus.opA};
  wire logic [32:0] b33 = {{17{bus.opB[15]}}, bus.opB};
  wire logic [32:0] c33 = {{17{bus.opC[15]}}, bus.opC};
  wire logic [32:0] w33 = {bus.mathWide[31], bus.mathWide};
  wire logic [16:0] usum = {1'b0, bus.opA} + {1'b0, bus.opB};
  wire logic bZero = (bus.opB == 16'h0000);
  wire logic [32:0] prod = 33'($signed(a33) * $signed(b33));
  wire logic [32:0] quo = bZero ? '0 : 33'($signed(a33) / $signed(b33));
  wire logic [32:0] rem = bZero ? '0 : 33'($signed(a33) % $signed(b33));
  wire logic [32:0] wq = bZero ? '0 : 33'($signed(w33) / $signed(b33));
  wire logic [32:0] wr = bZero ? '0 : 33'($signed(w33) % $signed(b33));
  wire logic [32:0] absR = rem[32] ? 33'(-rem) : rem;
  wire logic [32:0] absB = b33[32] ? 33'(-b33) : b33;
  // destination of the 16-bit divide is rounded, the math register keeps it unrounded
  wire logic roundUp = {absR[31:0], 1'b0} >= absB;
  wire logic [32:0] quoRnd = !roundUp ? quo : (bus.opA[15] ^ bus.opB[15]) ? 33'(quo - 33'h1) : 33'(quo + 33'h1);
  wire logic [15:0] absA = bus.opA[15] ? 16'(-bus.opA) : bus.opA;
  // divide by zero pushes toward the limit that matches the sign of operand A, in both divides
  wire logic [32:0] dzVal = {bus.opA[15], {32{~bus.opA[15]}}};

  logic [32:0] val;
  always_comb
  begin
    val = '0;
    bus.carry = 1'b0;
    bus.divZero = 1'b0;
    bus.wideLoad = 1'b0;
    bus.wideVal = '0;
    case (bus.op)
      OP_ADD:
      begin
        val = 33'(a33 + b33);
        bus.carry = usum[16];
      end
      OP_SUB:
      begin
        val = 33'(a33 - b33);
        bus.carry = bus.opA < bus.opB;
      end
      OP_PROD:
      begin
        val = prod;
        bus.wideLoad = 1'b1;
        bus.wideVal = prod[31:0];
      end
      OP_DIV:
      begin
        bus.divZero = bZero;
        val = bZero ? dzVal : quoRnd;
        bus.wideLoad = ~bZero;
        bus.wideVal = {quo[15:0], rem[15:0]};
      end
      OP_WDIV:
      begin
        bus.divZero = bZero;
        val = bZero ? dzVal : wq;
        bus.wideLoad = ~bZero;
        bus.wideVal = {wq[15:0], wr[15:0]};
      end
      OP_ZERO: val = '0;
      OP_ROOT: val = {25'h0, isqrt(absA)};
      OP_SCL: val = 33'(prod + c33);
      default: val = '0;
    endcase
  end

  // ****************************************
  // overflow handling
  // ****************************************
  assign bus.ovf = bus.divZero | ~fits16(val);
  // truncation never applies to the wide divide or to a divide by zero
  wire logic keepLow = bus.ovfSel && bus.op != OP_WDIV && !bus.divZero;
  assign bus.result = (bus.ovf && !keepLow) ? sat16(val) : val[15:0];

endmodule : imsu_arith

// ---- rtl/imsu_top.sv ----
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - code 80 adds operand A and operand B into the target word.
// - code 81 subtracts operand B from operand A into the target word.
// - code 82 multiplies, code 83 divides, results to target and math register.
// - code 84 divides the 32-bit math register by the operand, to both.
// - code 85 forces every bit of the target word to zero.
// - code 86 writes the integer square root of the operand.
// - code 87 multiplies the operand by a rate and adds an offset.
// - carry, overflow, zero, sign sit in bits 0 to 3, updated per instruction.
// - addition sets carry on carry out, clears it otherwise.
// - add overflow sets overflow and minor error, target gets the saturated limit.
// - with overflow select set, the truncated low 16 bits stay instead.
// - zero flag follows a zero result, cleared otherwise.
// - sign flag follows a negative result, cleared otherwise.
// - minor error trap sets on any math overflow or divide by zero.
// - trap still set at end or temporary end raises major fault code 0020.
// - low math word takes product low word and the remainder of either divide.
// - high math word takes product high word, unrounded quotient, wide quotient low word.
// - subtraction sets carry on borrow, clears it otherwise.
// - subtraction underflow sets overflow and trap, same saturate or truncate choice.
// - overflow select affects neither wide divide nor the math register content.
module imsu_top (
  input wire logic clock, // 100 MHz
  input wire logic resetn, // synchronous, active low
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  input wire logic wbWe, // wishbone write
  input wire logic [7:0] wbAdr, // byte address
  input wire logic [3:0] wbSel, // byte enables
  input wire logic [31:0] wbDatI, // write data
  output logic [31:0] wbDatO, // read data
  output logic wbAck, // wishbone acknowledge
  input wire logic execValid, // one-cycle instruction strobe
  input wire logic [7:0] funcCode, // instruction function code
  input wire logic [15:0] operandA, // first source
  input wire logic [15:0] operandB, // second source, rate for scaling
  input wire logic [15:0] operandC, // offset for scaling
  input wire logic endScan, // end or temporary end executing
  output logic targetValid, // target word write strobe
  output logic [15:0] targetData, // value for the target word
  output logic majorFault, // recoverable major fault held
  output logic [imsu_pkg::WORD_W-1:0] faultCode // fault code, zero when none
);
  import imsu_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic wbAck_r;
  logic [31:0] wbDat_r;
  logic [15:0] flags_r;
  logic ovfSel_r;
  logic trap_r;
  logic [15:0] mathLo_r;
  logic [15:0] mathHi_r;
  logic majorFault_r;
  logic [15:0] faultCode_r;
  logic targetValid_r;
  logic [15:0] targetData_r;

  imsu_alu_if aluBus ();

  imsu_arith u_arith (
    .bus(aluBus.alu)
  );

  // ****************************************
  // instruction path
  // ****************************************
  wire imsu_op_t execOp = decodeOp(funcCode);
  // unknown codes are ignored: no target write and no flag change
  wire logic execGo = execValid && execOp != OP_NONE;

  assign aluBus.op = execOp;
  assign aluBus.opA = operandA;
  assign aluBus.opB = operandB;
  assign aluBus.opC = operandC;
  assign aluBus.mathWide = {mathHi_r, mathLo_r};
  assign aluBus.ovfSel = ovfSel_r;

  wire logic resZero = (aluBus.result == 16'h0000);
  wire logic resSign = aluBus.result[15];
  wire logic [15:0] flagsHw = {flags_r[15:4], resSign, resZero, aluBus.ovf, aluBus.carry};
  wire logic trapSet = execGo && (aluBus.ovf || aluBus.divZero);
  wire logic faultSet = endScan && trap_r;

  // ****************************************
  // wishbone slave
  // ****************************************
  // one-cycle answer: request taken at edge n, ack stands until edge n+1
  // writes land at edge n+1, the edge at which the master samples ack
  wire logic busReq = wbCyc && wbStb && !wbAck_r;
  wire logic busWr = wbCyc && wbStb && wbWe && wbAck_r;
  wire logic selFlags = (wbAdr == REG_FLAGS);
  wire logic selCfg = (wbAdr == REG_CFG);
  wire logic selTrap = (wbAdr == REG_TRAP);
  wire logic selMathLo = (wbAdr == REG_MATH_LO);
  wire logic selMathHi = (wbAdr == REG_MATH_HI);
  wire logic selFault = (wbAdr == REG_FAULT);
  wire logic [15:0] cfgWord = {1'b0, ovfSel_r, 14'h0000};
  wire logic [15:0] cfgWr = wrMerge(cfgWord, wbDatI, wbSel);
  wire logic [15:0] trapWr = wrMerge({15'h0000, trap_r}, wbDatI, wbSel);
  wire logic [15:0] faultWr = wrMerge(faultCode_r, wbDatI, wbSel);
  // unmapped addresses still answer, reading zero and ignoring writes
  wire logic [15:0] rdWord =
    selFlags ? flags_r :
    selCfg ? cfgWord :
    selTrap ? {15'h0000, trap_r} :
    selMathLo ? mathLo_r :
    selMathHi ? mathHi_r :
    selFault ? faultCode_r : 16'h0000;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wbAck_r <= 1'b0;
      wbDat_r <= '0;
    end
    else
    begin
      wbAck_r <= busReq;
      wbDat_r <= busReq ? {16'h0000, rdWord} : '0;
    end
  end

  // ****************************************
  // status words; hardware update wins over a software write
  // ****************************************
  wire logic [15:0] flagsNxt = execGo ? flagsHw : (busWr && selFlags) ? wrMerge(flags_r, wbDatI, wbSel) : flags_r;
  wire logic trapNxt = trapSet | ((busWr && selTrap) ? trapWr[TRAP_MINOR] : trap_r);
  wire logic [31:0] mathNxt = (execGo && aluBus.wideLoad) ? aluBus.wideVal :
    {(busWr && selMathHi) ? wrMerge(mathHi_r, wbDatI, wbSel) : mathHi_r,
     (busWr && selMathLo) ? wrMerge(mathLo_r, wbDatI, wbSel) : mathLo_r};
  // fault is recoverable: software clears it by writing zero to the code
  wire logic [15:0] faultNxt = faultSet ? FAULT_MATH : (busWr && selFault) ? faultWr : faultCode_r;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      flags_r <= WORD_RESET;
      ovfSel_r <= 1'b0;
      trap_r <= 1'b0;
      mathLo_r <= WORD_RESET;
      mathHi_r <= WORD_RESET;
      faultCode_r <= WORD_RESET;
      majorFault_r <= 1'b0;
    end
    else
    begin
      flags_r <= flagsNxt;
      if (busWr && selCfg) ovfSel_r <= cfgWr[CFG_OVF_SEL];
      trap_r <= trapNxt;
      {mathHi_r, mathLo_r} <= mathNxt;
      faultCode_r <= faultNxt;
      majorFault_r <= (faultNxt != WORD_RESET);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      targetValid_r <= 1'b0;
      targetData_r <= WORD_RESET;
    end
    else
    begin
      targetValid_r <= execGo;
      if (execGo) targetData_r <= aluBus.result;
    end
  end

  assign wbAck = wbAck_r;
  assign wbDatO = wbDat_r;
  assign targetValid = targetValid_r;
  assign targetData = targetData_r;
  assign majorFault = majorFault_r;
  assign faultCode = faultCode_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  wire logic [16:0] chkSum = {1'b0, operandA} + {1'b0, operandB};
  wire logic [15:0] chkDif = operandA - operandB;
  wire logic chkAddOv = (operandA[15] == operandB[15]) && (chkSum[15] != operandA[15]);
  wire logic chkSubOv = (operandA[15] != operandB[15]) && (chkDif[15] != operandA[15]);
  wire logic isAdd = execValid && funcCode == FC_ADD;
  wire logic isSub = execValid && funcCode == FC_SUB;
  wire logic [31:0] chkProd = 32'($signed(operandA) * $signed(operandB));
  wire logic isMul = execValid && funcCode == FC_PROD;
  wire logic mulOv = |chkProd[31:15] && !(&chkProd[31:15]);
  wire logic bIsZero = (operandB == 16'h0000);
  wire logic isDiv = execValid && funcCode == FC_DIV && !bIsZero;
  wire logic [15:0] chkQuo = bIsZero ? 16'h0000 : 16'($signed(operandA) / $signed(operandB));
  wire logic [15:0] chkRem = bIsZero ? 16'h0000 : 16'($signed(operandA) % $signed(operandB));

  add_result_a: assert property (isAdd && !chkAddOv |=> targetValid && targetData == $past(chkSum[15:0]))
    else $error("add result wrong");
  sub_result_a: assert property (isSub && !chkSubOv |=> targetValid && targetData == $past(chkDif) && !flags_r[FLG_OVF])
    else $error("subtract result wrong");
  add_carry_a: assert property (isAdd |=> flags_r[FLG_CARRY] == $past(chkSum[16]))
    else $error("add carry wrong");
  sub_borrow_a: assert property (isSub |=> flags_r[FLG_CARRY] == $past(operandA < operandB))
    else $error("subtract borrow wrong");
  add_saturate_a: assert property (isAdd && chkAddOv && !ovfSel_r |=>
    flags_r[FLG_OVF] && trap_r && targetData == ($past(operandA[15]) ? NEG_LIMIT : POS_LIMIT))
    else $error("add saturation wrong");
  sub_truncate_a: assert property (isSub && chkSubOv && ovfSel_r |=> flags_r[FLG_OVF] && targetData == $past(chkDif))
    else $error("subtract truncation wrong");
  clear_word_a: assert property (execValid && funcCode == FC_ZERO |=> targetValid && targetData == 16'h0000)
    else $error("clear did not zero target");
  zero_sign_a: assert property (targetValid |-> flags_r[FLG_ZERO] == (targetData == 16'h0000)
    && flags_r[FLG_SIGN] == targetData[15])
    else $error("zero or sign flag wrong");
  trap_set_a: assert property (execValid && funcCode == FC_DIV && operandB == 16'h0000 |=> trap_r[*2])
    else $error("divide by zero did not trap");
  fault_raise_a: assert property (endScan && trap_r |=> majorFault && faultCode == FAULT_MATH)
    else $error("major fault not raised");
  mul_wide_a: assert property (isMul |=> {mathHi_r, mathLo_r} == $past(chkProd))
    else $error("math register wrong after multiply");
  bus_ack_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("wishbone ack not one cycle");

  sub_saturate_a: assert property (isSub && chkSubOv && !ovfSel_r |=>
    flags_r[FLG_OVF] && trap_r && targetData == ($past(operandA[15]) ? NEG_LIMIT : POS_LIMIT))
    else $error("subtract saturation wrong");

  add_truncate_a: assert property (isAdd && chkAddOv && ovfSel_r |=>
    flags_r[FLG_OVF] && trap_r && targetData == $past(chkSum[15:0]))
    else $error("add truncation wrong");

  add_no_ovf_a: assert property (isAdd && !chkAddOv |=> !flags_r[FLG_OVF])
    else $error("add overflow flag not cleared");

  mul_trap_a: assert property (isMul && mulOv |=> flags_r[FLG_OVF] && trap_r)
    else $error("multiply overflow did not trap");

  div_math_a: assert property (isDiv |=> mathHi_r == $past(chkQuo) && mathLo_r == $past(chkRem))
    else $error("math register wrong after divide");

  unknown_code_a: assert property (execValid && decodeOp(funcCode) == OP_NONE |=> !targetValid)
    else $error("unknown code wrote the target");

  add_ovf_c: cover property (isAdd && chkAddOv);
  sub_trunc_c: cover property (isSub && chkSubOv && ovfSel_r);
  div_zero_c: cover property (execValid && funcCode == FC_DIV && operandB == 16'h0000);
  wide_div_c: cover property (execValid && funcCode == FC_WDIV ##1 targetValid);
  fault_c: cover property (endScan && trap_r ##1 majorFault);

endmodule : imsu_top

// ---- dv/imsu_seq_model.sv ----
`timescale 1ns/1ns
// ****************************************
// instruction sequencer model
// ****************************************
module imsu_seq_model (
  input wire logic clock, // controller clock
  output logic execValid, // instruction strobe
  output logic [7:0] funcCode, // function code
  output logic [15:0] operandA, // first source
  output logic [15:0] operandB, // second source
  output logic [15:0] operandC, // scale offset
  output logic endScan // end of scan
);
  initial
  begin
    execValid = 1'b0;
    endScan = 1'b0;
    funcCode = 8'h00;
    operandA = 16'h0000;
    operandB = 16'h0000;
    operandC = 16'h0000;
  end

  task automatic issue(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clock);
    execValid <= 1'b1;
    funcCode <= fc;
    operandA <= a;
    operandB <= b;
    operandC <= c;
    @(posedge clock);
    execValid <= 1'b0;
    // idle sources never echo the last value
    operandA <= ~a;
    operandB <= ~b;
    operandC <= ~c;
  endtask : issue

  task automatic scanEnd();
    @(posedge clock);
    endScan <= 1'b1;
    @(posedge clock);
    endScan <= 1'b0;
  endtask : scanEnd
endmodule : imsu_seq_model

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
  import imsu_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, execValid, endScan, targetValid, majorFault;
  logic [7:0] funcCode;
  logic [15:0] operandA, operandB, operandC, targetData, faultCode;
  logic [31:0] rd;
  logic trapExp = 1'b0;
  int miscompares = 0;
  int nTests = 0;

  always #5 clock = ~clock;

  imsu_seq_model seq (.clock(clock), .execValid(execValid), .funcCode(funcCode), .operandA(operandA),
    .operandB(operandB), .operandC(operandC), .endScan(endScan));
  imsu_top dut (.clock(clock), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .execValid(execValid),
    .funcCode(funcCode), .operandA(operandA), .operandB(operandB), .operandC(operandC),
    .endScan(endScan), .targetValid(targetValid), .targetData(targetData), .majorFault(majorFault),
    .faultCode(faultCode));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chkBit(input logic got, input logic exp);
    nTests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBit

  task automatic results();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ****************************************
  // bus and instruction helpers
  // ****************************************
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    wbSel <= 4'hf;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    chkBit(wbAck, 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer

  task automatic rdReg(input logic [7:0] adr, input logic [15:0] exp);
    wbXfer(1'b0, adr, 32'h0);
    chk16(rd[15:0], exp);
  endtask : rdReg

  task automatic doOp(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
    input logic [15:0] exp);
    seq.issue(fc, a, b, c);
    #1;
    chkBit(targetValid, 1'b1);
    chk16(targetData, exp);
  endtask : doOp

  // returns {sign, zero, overflow, carry, target}
  function automatic logic [19:0] expAddSub(input logic sub, input logic [15:0] a, input logic [15:0] b,
    input logic sel);
    logic [16:0] u;
    logic [32:0] s;
    logic [15:0] r;
    logic ov;
    u = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    s = sub ? {{17{a[15]}}, a} - {{17{b[15]}}, b} : {{17{a[15]}}, a} + {{17{b[15]}}, b};
    ov = ~((&s[32:15]) | ~(|s[32:15]));
    r = (ov && !sel) ? (s[32] ? 16'h8000 : 16'h7fff) : s[15:0];
    return {r[15], r == 16'h0000, ov, u[16], r};
  endfunction : expAddSub

  initial
  begin
    #500000;
    miscompares++;
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [15:0] a, b;
    logic sub, sel;
    logic [19:0] e;
    void'($urandom(92));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    wbXfer(1'b1, 8'h18, 32'h0000ffff);
    for (int i = 0; i < 7; i++)
      rdReg(8'(4 * i), 16'h0000);
    chkBit(majorFault, 1'b0);
    for (int i = 0; i < 48; i++)
    begin
      sel = i[4];
      sub = i[0];
      a = 16'($urandom);
      b = 16'($urandom);
      // boundary pairs first in each overflow selection
      if (!i[3] && i < 24)
        case (i[2:1])
          2'h0: {a, b} = 32'h7fff0001;
          2'h1: {a, b} = 32'h80000001;
          2'h2: {a, b} = 32'hffff0001;
          default: {a, b} = 32'h0;
        endcase
      wbXfer(1'b1, REG_CFG, {16'h0, 1'b0, sel, 14'h0});
      e = expAddSub(sub, a, b, sel);
      trapExp |= e[17];
      doOp(sub ? FC_SUB : FC_ADD, a, b, 16'h0000, e[15:0]);
      rdReg(REG_FLAGS, {12'h0, e[19:16]});
      rdReg(REG_TRAP, {15'h0, trapExp});
    end
    wbXfer(1'b1, REG_CFG, 32'h0);
    wbXfer(1'b1, REG_TRAP, 32'h0);
    seq.scanEnd();
    #1;
    chkBit(majorFault, 1'b0);
    doOp(FC_ADD, 16'h7fff, 16'h7fff, 16'h0000, 16'h7fff);
    seq.scanEnd();
    #1;
    chkBit(majorFault, 1'b1);
    chk16(faultCode, 16'h0020);
    wbXfer(1'b1, REG_FAULT, 32'h0);
    wbXfer(1'b1, REG_TRAP, 32'h0);
    rdReg(REG_FAULT, 16'h0000);
    chkBit(majorFault, 1'b0);
    // 300 * -200 = 0xffff15a0, math register same for both selections
    for (int s = 0; s < 2; s++)
    begin
      wbXfer(1'b1, REG_CFG, {16'h0, 1'b0, s[0], 14'h0});
      doOp(FC_PROD, 16'h012c, 16'hff38, 16'h0000, s[0] ? 16'h15a0 : 16'h8000);
      rdReg(REG_MATH_HI, 16'hffff);
      rdReg(REG_MATH_LO, 16'h15a0);
    end
    // 7 / -2: rounded -4, truncated -3, remainder 1
    doOp(FC_DIV, 16'h0007, 16'hfffe, 16'h0000, 16'hfffc);
    rdReg(REG_MATH_HI, 16'hfffd);
    rdReg(REG_MATH_LO, 16'h0001);
    wbXfer(1'b1, REG_TRAP, 32'h0);
    doOp(FC_DIV, 16'h0005, 16'h0000, 16'h0000, 16'h7fff);
    rdReg(REG_TRAP, 16'h0001);
    rdReg(REG_MATH_HI, 16'hfffd);
    // 65536 / 3 = 21845 remainder 1
    wbXfer(1'b1, REG_MATH_HI, 32'h1);
    wbXfer(1'b1, REG_MATH_LO, 32'h0);
    doOp(FC_WDIV, 16'h0003, 16'h0003, 16'h0000, 16'h5555);
    rdReg(REG_MATH_HI, 16'h5555);
    rdReg(REG_MATH_LO, 16'h0001);
    doOp(FC_ZERO, 16'h1234, 16'h5678, 16'h0000, 16'h0000);
    rdReg(REG_FLAGS, 16'h0004);
    doOp(FC_ROOT, 16'hffce, 16'h0000, 16'h0000, 16'h0007);
    doOp(FC_SCL, 16'h000a, 16'h0014, 16'hfffb, 16'h00c3);
    seq.issue(8'h58, 16'h0001, 16'h0001, 16'h0000);
    #1;
    chkBit(targetValid, 1'b0);
    chk16(targetData, 16'h00c3);
    results();
  end
endmodule : tb
